// File: common/pi_seq_defines.svh
`ifndef PI_SEQ_DEFINES_SVH
`define PI_SEQ_DEFINES_SVH

// ----------------------------------------------------------------
// Timing figures in microseconds.
// ----------------------------------------------------------------
`define DRIVE_US 1500
`define BLANK_US 100
`define SAMPLE_US 1200
`define SAMPLE_PERIOD_US 4
`define WINDOW_US 100
`define EARLY_US 130
`define STANDARD_US 300
`define ZERO_US 1000
`define CALC_US 325
`define CYCLE_US 3125

// ----------------------------------------------------------------
// Counts, widths and the clock rate.
// ----------------------------------------------------------------
`define SAMPLE_COUNT 300
`define WINDOW_SAMPLES 25
`define CHANNEL_COUNT 4
`define ADC_BITS 12
`define SIGNAL_GROUP 8
`define CLOCK_HZ 10000000

`endif

// File: common/pi_seq_pkg.sv
package pi_seq_pkg;

  // Sequencer phases, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_DRIVE = 5'b00010,
    ST_BLANK = 5'b00100,
    ST_SAMP  = 5'b01000,
    ST_CALC  = 5'b10000
  } seq_state_t;

  // Averaging window select.
  typedef enum logic [1:0] {
    WIN_EARLY = 2'h0,
    WIN_STD   = 2'h1,
    WIN_ZERO  = 2'h2,
    WIN_NONE  = 2'h3
  } window_t;

endpackage

// File: design/pulse_induction_measure_sequencer.sv
// Summary of operation
// R1: Assert coil drive for exactly 1500 us.
// R2: Release drive, keep off rest of cycle.
// R3: Wait 100 us blanking, no sampling.
// R4: 300 conversions every 4 us, buffered.
// R5: Keep every result at 12 bits.
// R6: Three windows, each 100 us wide.
// R7: Average 25 early samples from 130 us; the code starts at sample 32, taken at 128 us.
// R8: Average 25 standard samples from 300 us.
// R9: Average 25 zero samples from 1000 us.
// R10: Hold 325 us calculation interval after sampling.
// R11: Rotate four channels, 3125 us each.
// R12: Every eighth pass, average and subtract zero.
// R13: Durations counted in clocks of parameter rate.
// R14: One-cycle valid strobe with channel index.
`timescale 1ns/100ps
`include "pi_seq_defines.svh"

module pulse_induction_measure_sequencer #(
  parameter int CLK_HZ = `CLOCK_HZ,
  parameter int ADC_W = `ADC_BITS,
  parameter int NUM_SAMPLES = `SAMPLE_COUNT,
  parameter int WIN_SAMPLES = `WINDOW_SAMPLES
) (
  input wire logic sys_clk,
  input wire logic reset,
  output logic coil_drive,
  output logic [1:0] coil_channel,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [ADC_W-1:0] adc_data,
  output logic sample_valid,
  input wire logic sample_ready,
  output logic [ADC_W-1:0] sample_data,
  output logic [8:0] sample_index,
  output logic [1:0] sample_channel,
  output logic levels_valid,
  output logic [1:0] levels_channel,
  output logic [ADC_W-1:0] early_level,
  output logic [ADC_W-1:0] standard_level,
  output logic [ADC_W-1:0] zero_level,
  output logic signal_valid,
  output logic [ADC_W:0] early_signal,
  output logic [ADC_W:0] standard_signal
);
  import pi_seq_pkg::*;

  // ----------------------------------------------------------------
  // Cycle counts derived from the clock rate.
  // ----------------------------------------------------------------
  localparam int CPU = CLK_HZ / 1000000; // Clocks per microsecond.
  localparam int DRIVE_CYC = `DRIVE_US * CPU; // R13
  localparam int BLANK_CYC = `BLANK_US * CPU; // R13
  localparam int SAMPLE_CYC = `SAMPLE_US * CPU; // R13
  localparam int SPACING_CYC = `SAMPLE_PERIOD_US * CPU; // R13
  localparam int CALC_CYC = `CALC_US * CPU; // R13
  localparam int EARLY_IDX = `EARLY_US / `SAMPLE_PERIOD_US; // Sample 32.
  localparam int STD_IDX = `STANDARD_US / `SAMPLE_PERIOD_US; // Sample 75.
  localparam int ZERO_IDX = `ZERO_US / `SAMPLE_PERIOD_US; // Sample 250.
  localparam int WIN_LEN = `WINDOW_US / `SAMPLE_PERIOD_US; // 25 samples.
  localparam int TW = 16; // Width of the phase timer.

  // ----------------------------------------------------------------
  // Sequencer state.
  // ----------------------------------------------------------------
  seq_state_t state; // Current phase.
  logic [TW-1:0] timer; // Clocks spent in current phase.
  logic [TW-1:0] pace; // Clocks since last conversion trigger.
  logic [8:0] taken; // Conversions triggered this pass.
  logic [8:0] stored; // Results received this pass.
  logic [1:0] chan; // Channel under measurement.
  logic last_phase_clk; // Final clock of the current phase.

  // The phase ends when its timer reaches the phase length minus one.
  always_comb begin
    case (state)
      ST_DRIVE: last_phase_clk = (timer == TW'(DRIVE_CYC - 1));
      ST_BLANK: last_phase_clk = (timer == TW'(BLANK_CYC - 1));
      ST_SAMP: last_phase_clk = (timer == TW'(SAMPLE_CYC - 1));
      ST_CALC: last_phase_clk = (timer == TW'(CALC_CYC - 1));
      default: last_phase_clk = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Phase sequencing.
  // ----------------------------------------------------------------
  // Each channel walks drive, blank, sample and calc, then rotates.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      chan <= 2'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= ST_DRIVE; // R1
        end
        ST_DRIVE: begin
          if (last_phase_clk) begin
            state <= ST_BLANK; // R2
          end
        end
        ST_BLANK: begin
          if (last_phase_clk) begin
            state <= ST_SAMP; // R3
          end
        end
        ST_SAMP: begin
          if (last_phase_clk) begin
            state <= ST_CALC; // R10
          end
        end
        ST_CALC: begin
          if (last_phase_clk) begin
            state <= ST_DRIVE; // R11
            chan <= chan + 2'h1; // R11
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // The phase timer restarts at every phase boundary.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      timer <= '0;
    end else if (last_phase_clk) begin
      timer <= '0;
    end else begin
      timer <= timer + TW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Coil drive output.
  // ----------------------------------------------------------------
  // Drive is high exactly while the sequencer is in the drive phase.
  // It is set from the phase about to begin, so every pulse, the first and each
  // one after a calc interval alike, spans the full drive count.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      coil_drive <= 1'b0;
      coil_channel <= 2'h0;
    end else begin
      coil_drive <= (state == ST_IDLE) || (state == ST_DRIVE && !last_phase_clk) ||
        (state == ST_CALC && last_phase_clk); // R1 R2
      coil_channel <= (state == ST_CALC && last_phase_clk) ? chan + 2'h1 : chan;
    end
  end

  // ----------------------------------------------------------------
  // Conversion pacing.
  // ----------------------------------------------------------------
  // One trigger every spacing interval, only inside the sampling phase.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pace <= '0;
      taken <= 9'h000;
      adc_start <= 1'b0;
    end else if (state != ST_SAMP) begin
      pace <= '0; // R3
      taken <= 9'h000;
      adc_start <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      if (pace == TW'(SPACING_CYC - 1)) begin
        pace <= '0;
      end else begin
        pace <= pace + TW'(1);
      end
      if (pace == '0 && taken < 9'(NUM_SAMPLES)) begin
        adc_start <= 1'b1; // R4
        taken <= taken + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result capture into the buffer path.
  // ----------------------------------------------------------------
  logic accept; // A result is accepted this cycle.
  logic buf_ready; // Buffer can take a word.
  logic buf_valid; // Buffer holds a word.
  logic [ADC_W+10:0] buf_out; // Word leaving the buffer.
  assign accept = adc_done && (state == ST_SAMP || state == ST_CALC) &&
    (stored < 9'(NUM_SAMPLES)) && buf_ready;

  // Result counter gives each word its position in the pass.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stored <= 9'h000;
    end else if (state == ST_DRIVE) begin
      stored <= 9'h000;
    end else if (accept) begin
      stored <= stored + 9'h001; // R4
    end
  end

  skid_buffer #(
    .WIDTH(ADC_W + 11)
  ) u_buf (
    .sys_clk(sys_clk),
    .reset(reset),
    .in_valid(accept),
    .in_ready(buf_ready),
    .in_data({chan, stored, adc_data}), // R5
    .out_valid(buf_valid),
    .out_ready(sample_ready || !sample_valid),
    .out_data(buf_out)
  );

  // Registered output stage for the sample stream.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sample_valid <= 1'b0;
      sample_data <= '0;
      sample_index <= 9'h000;
      sample_channel <= 2'h0;
    end else if (sample_ready || !sample_valid) begin
      sample_valid <= buf_valid;
      sample_data <= buf_out[ADC_W-1:0]; // R5
      sample_index <= buf_out[ADC_W+8:ADC_W];
      sample_channel <= buf_out[ADC_W+10:ADC_W+9];
    end
  end

  // ----------------------------------------------------------------
  // Averaging windows.
  // ----------------------------------------------------------------
  logic [ADC_W-1:0] win_mean [0:2]; // Mean of each window.
  localparam int WIN_START [0:2] = '{EARLY_IDX, STD_IDX, ZERO_IDX};

  // One accumulator per window, each fed from its own sample range.
  genvar w;
  generate
    for (w = 0; w < 3; w++) begin : g_win
      logic in_win;
      assign in_win = (stored >= 9'(WIN_START[w])) &&
        (stored < 9'(WIN_START[w] + WIN_LEN)); // R6 R7 R8 R9
      window_accum #(
        .DATA_W(ADC_W),
        .NUM(WIN_SAMPLES)
      ) u_acc (
        .sys_clk(sys_clk),
        .reset(reset),
        .clear(state == ST_DRIVE),
        .add(accept && in_win),
        .sample(adc_data),
        .mean(win_mean[w])
      );
    end
  endgenerate

  // Levels latch and strobe once per channel at end of calc interval.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      levels_valid <= 1'b0;
      levels_channel <= 2'h0;
      early_level <= '0;
      standard_level <= '0;
      zero_level <= '0;
    end else begin
      levels_valid <= 1'b0;
      if (state == ST_CALC && last_phase_clk) begin
        levels_valid <= 1'b1; // R14
        levels_channel <= chan; // R14
        early_level <= win_mean[0]; // R7
        standard_level <= win_mean[1]; // R8
        zero_level <= win_mean[2]; // R9
      end
    end
  end

  // ----------------------------------------------------------------
  // Eight-pass signal derivation per channel.
  // ----------------------------------------------------------------
  localparam int GW = ADC_W + 3; // Sum width for eight levels.
  logic [GW-1:0] sum_e [0:3]; // Early sums per channel.
  logic [GW-1:0] sum_s [0:3]; // Standard sums per channel.
  logic [GW-1:0] sum_z [0:3]; // Zero sums per channel.
  logic [2:0] passes [0:3]; // Passes so far per channel.
  logic [GW-1:0] ne, ns, nz; // Sums including the latest pass.
  assign ne = sum_e[levels_channel] + GW'(early_level);
  assign ns = sum_s[levels_channel] + GW'(standard_level);
  assign nz = sum_z[levels_channel] + GW'(zero_level);

  // Sums gather eight passes, then yield two zero-corrected signals.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < 4; c++) begin
        sum_e[c] <= '0;
        sum_s[c] <= '0;
        sum_z[c] <= '0;
        passes[c] <= 3'h0;
      end
      signal_valid <= 1'b0;
      early_signal <= '0;
      standard_signal <= '0;
    end else begin
      signal_valid <= 1'b0;
      if (levels_valid) begin
        passes[levels_channel] <= passes[levels_channel] + 3'h1;
        if (passes[levels_channel] == 3'h7) begin
          sum_e[levels_channel] <= '0;
          sum_s[levels_channel] <= '0;
          sum_z[levels_channel] <= '0;
          signal_valid <= 1'b1; // R12
          early_signal <= (ADC_W+1)'({1'b0, ne[GW-1:3]}) - (ADC_W+1)'({1'b0, nz[GW-1:3]}); // R12
          standard_signal <= (ADC_W+1)'({1'b0, ns[GW-1:3]}) - (ADC_W+1)'({1'b0, nz[GW-1:3]}); // R12
        end else begin
          sum_e[levels_channel] <= ne;
          sum_s[levels_channel] <= ns;
          sum_z[levels_channel] <= nz;
        end
      end
    end
  end

endmodule // pulse_induction_measure_sequencer

// File: design/skid_buffer.sv
`timescale 1ns/100ps

// Two-entry buffer with valid/ready on both sides.
module skid_buffer #(
  parameter int WIDTH = 14
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem [0:1]; // Storage for two words.
  logic wr_ptr; // Next slot to fill.
  logic rd_ptr; // Next slot to drain.
  logic [1:0] count; // Words held.

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];

  // Write side stores a word when accepted.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy track pushes and pops.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule // skid_buffer

// File: design/window_accum.sv
`timescale 1ns/100ps

// Sums samples for one averaging window and divides by the sample count.
module window_accum #(
  parameter int DATA_W = 12,
  parameter int NUM = 25
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic add,
  input wire logic [DATA_W-1:0] sample,
  output logic [DATA_W-1:0] mean
);

  localparam int SUM_W = DATA_W + $clog2(NUM + 1);

  logic [SUM_W-1:0] sum; // Running sum of the window.

  // The sum restarts on clear and grows by each added sample.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sum <= '0;
    end else if (clear) begin
      sum <= '0;
    end else if (add) begin
      sum <= sum + SUM_W'(sample);
    end
  end

  // Division by a constant; truncates toward zero.
  logic [SUM_W-1:0] quotient;
  assign quotient = sum / SUM_W'(NUM);
  assign mean = quotient[DATA_W-1:0];

endmodule // window_accum

// File: verification/adc_front_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Sampling front end: answers each start with one result.
// ----------------------------------------------------------------
module adc_front_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic coil_drive,
  input wire logic adc_start,
  input wire logic slow,
  input wire logic [11:0] base,
  input wire logic [11:0] step,
  output logic adc_done = 1'b0,
  output logic [11:0] adc_data = 12'h000
);
  logic pend; // A conversion is under way.
  logic wt; // One extra clock of delay remains.
  logic [11:0] idx; // Result number within the cycle.

  // Results follow a ramp; between results the data toggles.
  always @(negedge sys_clk or posedge reset) begin
    if (reset) begin
      adc_done <= 1'b0;
      adc_data <= 12'h000;
      pend <= 1'b0;
      wt <= 1'b0;
      idx <= 12'h000;
    end else begin
      adc_done <= 1'b0;
      adc_data <= ~adc_data;
      if (coil_drive) begin
        idx <= 12'h000;
      end
      if (adc_start) begin
        pend <= 1'b1;
        wt <= slow;
      end else if (pend && wt) begin
        wt <= 1'b0;
      end else if (pend) begin
        adc_done <= 1'b1;
        adc_data <= base + idx * step;
        idx <= idx + 12'h001;
        pend <= 1'b0;
      end
    end
  end
endmodule // adc_front_model

// File: verification/pims_checker.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Timing checker for the measurement sequencer ports.
// ----------------------------------------------------------------
module pims_checker #(
  parameter int CLK_HZ = 10000000
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic coil_drive,
  input wire logic [1:0] coil_channel,
  input wire logic adc_start,
  input wire logic levels_valid,
  input wire logic signal_valid,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [11:0] sample_data,
  input wire logic [8:0] sample_index
);
  localparam int CPU = CLK_HZ / 1000000; // Clocks per microsecond.
  localparam int DRV = 1500 * CPU; // Drive pulse length.
  localparam int CYC = 3125 * CPU; // Whole channel cycle.
  localparam int SP = 4 * CPU; // Conversion spacing.
  localparam int FIRST = 1600 * CPU; // Drive plus blanking.
  logic drv_q; // Drive level one clock ago.
  int since; // Clocks since the drive pulse began.
  int gap; // Clocks since the last conversion start.
  int n_adc; // Conversion starts in this cycle.

  // Cycle position, restarted by each rising drive.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      drv_q <= 1'b0;
      since <= 0;
    end else begin
      drv_q <= coil_drive;
      if (coil_drive && !drv_q) begin
        since <= 1;
      end else if (since != 0) begin
        since <= since + 1;
      end
    end
  end

  // Conversion count and spacing.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      n_adc <= 0;
      gap <= 0;
    end else begin
      gap <= adc_start ? 1 : gap + 1;
      if (coil_drive && !drv_q) begin
        n_adc <= 0;
      end else if (adc_start) begin
        n_adc <= n_adc + 1;
      end
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // A stalled word must be held until taken.
  sequence s_stall;
    sample_valid && !sample_ready;
  endsequence
  sequence s_held;
    sample_valid && $stable(sample_data) && $stable(sample_index);
  endsequence

  AST_DRIVE_LEN: assert property ($fell(coil_drive) |-> since == DRV)
    else $error("drive pulse length wrong");
  AST_DRIVE_OFF: assert property ((since >= DRV && since < CYC) |-> !coil_drive)
    else $error("drive on after pulse end");
  AST_CYCLE_LEN: assert property (($rose(coil_drive) && since != 0) |-> since == CYC)
    else $error("channel cycle length wrong");
  AST_FIRST_CONV: assert property (adc_start |-> since >= FIRST && !coil_drive)
    else $error("conversion during drive or blanking");
  AST_CONV_GAP: assert property ((adc_start && n_adc != 0) |-> gap == SP)
    else $error("conversion spacing wrong");
  AST_CONV_COUNT: assert property (($rose(coil_drive) && since != 0) |-> n_adc == 300)
    else $error("conversion count wrong");
  AST_ROTATE: assert property ($changed(coil_channel) |-> coil_channel == $past(coil_channel) + 2'h1)
    else $error("channel order wrong");
  AST_LEVELS_PULSE: assert property (levels_valid |=> !levels_valid)
    else $error("levels strobe too long");
  AST_SIGNAL_AFTER: assert property (signal_valid |-> $past(levels_valid))
    else $error("signal strobe without levels");
  AST_STALL_HOLD: assert property (s_stall |=> s_held)
    else $error("stalled sample not held");
endmodule // pims_checker

bind pulse_induction_measure_sequencer pims_checker #(.CLK_HZ(CLK_HZ)) i_pims_checker (
  .sys_clk(sys_clk), .reset(reset), .coil_drive(coil_drive), .coil_channel(coil_channel),
  .adc_start(adc_start), .levels_valid(levels_valid), .signal_valid(signal_valid),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
  .sample_index(sample_index));

// File: verification/tb.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Self-checking bench for the measurement sequencer.
// ----------------------------------------------------------------
module tb;
  localparam int HZ = 1000000; // One clock per microsecond keeps the run short.
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic coil_drive, adc_start, adc_done, sample_valid, levels_valid, signal_valid;
  logic slow = 1'b0;
  logic sample_ready = 1'b0;
  logic [1:0] coil_channel, sample_channel, levels_channel;
  logic [11:0] adc_data, sample_data, early_level, standard_level, zero_level;
  logic [11:0] base = 12'h000;
  logic [11:0] step = 12'h000;
  logic [11:0] b, s, e, st, z;
  logic [8:0] sample_index;
  logic [12:0] early_signal, standard_signal, es, ss;
  logic [31:0] seed = 32'hFDCB;
  logic drv_q = 1'b0;
  logic [11:0] pq[$]; // Ramp settings of cycles not yet reported.
  int sum[4][3]; // Level sums per channel.
  int cnt[4]; // Levels seen per channel since last signal.
  int n_mismatch = 0;
  int checks = 0;
  int cyc = -1;
  int n_lv = 0;
  int n_sig = 0;
  int n_done = 0;
  int exp_idx = 0;
  int ch;

  always #50 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Truncated mean of 25 ramp results from a first index.
  function automatic logic [11:0] mean25(logic [11:0] bb, logic [11:0] ss2, int first);
    int acc;
    acc = 0;
    for (int i = first; i < first + 25; i++) begin
      acc += 12'(bb + 12'(i) * ss2);
    end
    return 12'(acc / 25);
  endfunction

  task automatic check(string what, logic [12:0] exp, logic [12:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  pulse_induction_measure_sequencer #(.CLK_HZ(HZ)) i_pulse_induction_measure_sequencer (
    .sys_clk(sys_clk), .reset(reset), .coil_drive(coil_drive), .coil_channel(coil_channel),
    .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
    .sample_index(sample_index), .sample_channel(sample_channel),
    .levels_valid(levels_valid), .levels_channel(levels_channel),
    .early_level(early_level), .standard_level(standard_level), .zero_level(zero_level),
    .signal_valid(signal_valid), .early_signal(early_signal),
    .standard_signal(standard_signal));

  adc_front_model i_adc_front_model (
    .sys_clk(sys_clk), .reset(reset), .coil_drive(coil_drive), .adc_start(adc_start),
    .slow(slow), .base(base), .step(step), .adc_done(adc_done), .adc_data(adc_data));

  // Ramp and ready stimulus first, then monitor, all at the falling edge.
  always @(negedge sys_clk) begin
    if (!reset) begin
      if (coil_drive && !drv_q) begin
        cyc++;
        check("coil_channel", 13'(cyc % 4), 13'(coil_channel));
        base = 12'(rnd());
        step = 12'(rnd());
        slow = cyc[0];
        pq.push_back(base);
        pq.push_back(step);
        exp_idx = 0;
        n_done = 0;
      end
      drv_q = coil_drive;
      if (adc_done) begin
        n_done++;
      end
      // Cycle 2 stalls long enough for the buffer to fill and refuse.
      sample_ready = (cyc == 2 && n_done > 285 && n_done < 296) ? 1'b0 : (rnd() % 4 != 0);
      if (sample_valid && sample_ready && !(cyc == 2 && sample_index > 285)) begin
        check("sample_index", 13'(exp_idx), 13'(sample_index));
        check("sample_data", 13'(12'(base + 12'(exp_idx) * step)), 13'(sample_data));
        check("sample_channel", 13'(cyc % 4), 13'(sample_channel));
        exp_idx = sample_index + 1;
      end
      if (levels_valid) begin
        b = pq.pop_front();
        s = pq.pop_front();
        ch = n_lv % 4;
        e = mean25(b, s, 32);
        st = mean25(b, s, 75);
        z = mean25(b, s, 250);
        check("levels_channel", 13'(ch), 13'(levels_channel));
        check("early_level", 13'(e), 13'(early_level));
        check("standard_level", 13'(st), 13'(standard_level));
        check("zero_level", 13'(z), 13'(zero_level));
        sum[ch][0] += e;
        sum[ch][1] += st;
        sum[ch][2] += z;
        cnt[ch]++;
        if (cnt[ch] == 8) begin
          es = 13'(sum[ch][0] / 8 - sum[ch][2] / 8);
          ss = 13'(sum[ch][1] / 8 - sum[ch][2] / 8);
          sum[ch] = '{0, 0, 0};
          cnt[ch] = 0;
        end
        n_lv++;
      end
      if (signal_valid) begin
        n_sig++;
        check("early_signal", es, early_signal);
        check("standard_signal", ss, standard_signal);
      end
    end
  end

  // Reset, then run until channel 0 has produced its first signal pair.
  initial begin
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    wait (n_lv >= 29 && n_sig >= 1);
    repeat (2) @(negedge sys_clk);
    check("signal_count", 13'(1), 13'(n_sig));
    complete_run();
  end

  // Watchdog: 32 channel cycles of 3125 clocks at 100 ns.
  initial begin
    #10000000;
    n_mismatch++;
    complete_run();
  end
endmodule // tb
